/* machine_clock_mode_status_tb_top.sv */
// Self-checking bench for the machine clock mode block
`timescale 1ns/1ps
module machine_clock_mode_status_tb_top;
  typedef struct {logic [1:0] mode; int cnt; logic hold;} mck_exp_t;
  logic               clk, rst, psel, penable, pwrite, pready, pslverr;
  logic               stopWake, pllMainAligned, clkHold, tbtClear, switchBusy;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, r;
  logic [3:0]         pstrb;
  logic [2:0]         pllMult;
  mck_pkg::mck_mode_t clkSrc;
  logic [1:0]         cws, cm;
  logic               cs, cp, prevBusy, prevHold;
  int                 num_errors, comparisons, cnt, cyc;
  logic [35:0]        expRd[$];
  logic [35:0]        lenSeen, lenExp;
  mck_exp_t           expSw[$];
  mck_exp_t           x;

  mck_clock_mode #(.WAIT_PLL_FIXED(18'h0_0010), .WAIT_TAP0(18'h0_0008),
    .WAIT_TAP1(18'h0_000C), .WAIT_TAP2(18'h0_0014), .WAIT_TAP3(18'h0_0018)) i_mck_clock_mode (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .stopWake(stopWake), .pllMainAligned(pllMainAligned),
    .clkSrc(clkSrc), .clkHold(clkHold), .pllMult(pllMult), .tbtClear(tbtClear),
    .switchBusy(switchBusy));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string n, input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %0s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic conclude;
    if (expRd.size() != 0 || expSw.size() != 0) num_errors++;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [15:0] rv(input logic f15, input logic f14);
    return {f15, f14, cws, cs, cp, cm, 8'h00};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [1:0] ws, input logic s, input logic p, input logic [1:0] m);
    logic [15:0] v;
    r = $urandom();
    v = {r[1:0], ws, s, p, m, r[9:2]};
    if (cp) cm = m;
    cws = ws;
    cs = s;
    cp = p;
    apb(1'b1, 12'h000, {r[31:16], v});
  endtask

  task automatic rd(input logic f15, input logic f14);
    expRd.push_back({{1'b0, cm} + 3'h1, 1'b0, 16'h0000, rv(f15, f14)});
    apb(1'b0, 12'h000, $urandom());
  endtask

  task automatic sw(input logic [1:0] m, input int c, input logic h);
    mck_exp_t y;
    y.mode = m;
    y.cnt = c;
    y.hold = h;
    expSw.push_back(y);
  endtask

  task automatic idle;
    @(posedge clk);
    for (int k = 0; k < 3000 && switchBusy !== 1'b0; k++) @(posedge clk);
    if (switchBusy !== 1'b0) begin
      num_errors++;
      conclude();
    end
    @(posedge clk);
  endtask

  // Result watcher
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      chk("read", {pllMult, pslverr, prdata}, expRd.pop_front());
    end
    if (prevBusy && switchBusy === 1'b0) begin
      x = expSw.pop_front();
      chk("clkSrc", 36'(clkSrc), 36'(x.mode));
      chk("clkHold", 36'(prevHold), 36'(x.hold));
      lenSeen = (x.cnt == 0) ? 36'(cnt >= 1 && cnt <= mck_pkg::PLL_ALIGN_MAX) : 36'(cnt);
      lenExp = (x.cnt == 0) ? 36'h1 : 36'(x.cnt);
      chk("waitLen", lenSeen, lenExp);
    end
    cnt = tbtClear ? 0 : cnt + 1;
    prevBusy = (switchBusy === 1'b1);
    prevHold = clkHold;
  end

  always @(posedge clk) begin
    pllMainAligned <= 1'($urandom());
    cyc++;
    if (cyc == 10000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, stopWake, pllMainAligned, prevBusy, prevHold} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    {num_errors, comparisons, cnt, cyc} = '0;
    {cws, cs, cp, cm} = 6'h3C;
    r = $urandom(80);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(1'b1, 1'b1);
    expRd.push_back({3'h1, 1'b1, 32'h0000_0000});
    apb(1'b0, 12'h004, $urandom());
    for (int k = 0; k < 4; k++) begin
      wr(2'(k), 1'b1, 1'b1, 2'(k));
      rd(1'b1, 1'b1);
    end
    $display("test registers done");
    sw(mck_pkg::MODE_PLL, 17, 1'b0);
    wr(2'h1, 1'b1, 1'b0, 2'h3);
    rd(1'b1, 1'b1);
    idle;
    rd(1'b1, 1'b0);
    sw(mck_pkg::MODE_MAIN, 0, 1'b0);
    wr(2'h1, 1'b1, 1'b1, 2'h3);
    idle;
    $display("test pll done");
    sw(mck_pkg::MODE_SUB, 2601, 1'b0);
    wr(2'h1, 1'b0, 1'b1, 2'h3);
    rd(1'b1, 1'b1);
    idle;
    rd(1'b0, 1'b1);
    sw(mck_pkg::MODE_MAIN, 21, 1'b0);
    wr(2'h2, 1'b1, 1'b1, 2'h3);
    rd(1'b0, 1'b1);
    idle;
    sw(mck_pkg::MODE_SUB, 2601, 1'b0);
    wr(2'h3, 1'b0, 1'b0, 2'h3);
    idle;
    sw(mck_pkg::MODE_PLL, 25, 1'b0);
    wr(2'h3, 1'b1, 1'b0, 2'h3);
    idle;
    sw(mck_pkg::MODE_MAIN, 0, 1'b0);
    wr(2'h0, 1'b1, 1'b1, 2'h0);
    idle;
    rd(1'b1, 1'b1);
    $display("test subclock done");
    sw(mck_pkg::MODE_MAIN, 9, 1'b1);
    stopWake <= 1'b1;
    @(posedge clk);
    stopWake <= 1'b0;
    idle;
    $display("test stop exit done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    {cws, cs, cp, cm} = 6'h3C;
    @(posedge clk);
    rd(1'b1, 1'b1);
    $display("test reset done");
    conclude();
  end
endmodule

/* mck_clock_mode.sv */
// Clock select register and machine clock mode sequencer behind APB
`timescale 1ns/1ps
// Notes on behaviour
// - Bits 13:12 pick one of four wait taps
// - Selected wait on stop exit and sub-to-main
// - Main-to-PLL uses fixed 2^14 clock wait
// - Sub-to-PLL uses selected wait time
// - Reset restores wait select field
// - Bit 14 shows main versus PLL
// - PLL flag stays 1 during PLL wait
// - Bit 15 shows main versus subclock
// - Sub flag 0 while leaving subclock
// - Sub flag 1 while entering subclock
// - Exactly three modes: main, sub, PLL
// - Keep main clock until PLL wait ends
// - PLL-to-main within one to eight cycles
// - Both selects zero means subclock wins
// - Multiplier field gives factor one to four
module mck_clock_mode #(
  parameter logic [17:0] WAIT_PLL_FIXED = 18'h0_4000,
  parameter logic [17:0] WAIT_TAP0      = 18'h0_0400,
  parameter logic [17:0] WAIT_TAP1      = 18'h0_2000,
  parameter logic [17:0] WAIT_TAP2      = 18'h0_8000,
  parameter logic [17:0] WAIT_TAP3      = 18'h2_0000
) (
  input  logic                clk,
  input  logic                rst,
  input  logic                psel,
  input  logic                penable,
  input  logic                pwrite,
  input  logic [11:0]         paddr,
  input  logic [31:0]         pwdata,
  input  logic [3:0]          pstrb,
  output logic                pready,
  output logic [31:0]         prdata,
  output logic                pslverr,
  input  logic                stopWake,
  input  logic                pllMainAligned,
  output mck_pkg::mck_mode_t  clkSrc,
  output logic                clkHold,
  output logic [2:0]          pllMult,
  output logic                tbtClear,
  output logic                switchBusy
);
  mck_wait_if wif ();

  mck_pkg::mck_state_t state_q, stateD;
  mck_pkg::mck_mode_t  mode_q, modeD;
  mck_pkg::mck_mode_t  pend_q, pendD;
  mck_pkg::mck_mode_t  target;
  logic [1:0]          wsSel_q;
  logic [1:0]          multSel_q;
  logic                pllSel_q;
  logic                subSel_q;
  logic [2:0]          pllMult_q;
  logic [31:0]         prdata_q;
  logic                setup;
  logic                access;
  logic                mapped;
  logic                wrEn;
  logic                pllRunFlag;
  logic                subRunFlag;
  logic [15:0]         regView;
  logic                tStart;
  logic [17:0]         tLen;
  logic                tDone;
  logic [17:0]         wsLenSel;
  logic                stRun;

  function automatic logic [17:0] wsLen(input logic [1:0] sel);
    case (sel)
      2'h0:    wsLen = WAIT_TAP0;
      2'h1:    wsLen = WAIT_TAP1;
      2'h2:    wsLen = WAIT_TAP2;
      default: wsLen = WAIT_TAP3;
    endcase
  endfunction

  // Bus decode
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign mapped  = (paddr == mck_pkg::CKSEL_OFF);
  assign wrEn    = access && pwrite && mapped && pstrb[1];
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = prdata_q;

  // Mode request, subclock first
  assign target = !subSel_q ? mck_pkg::MODE_SUB :
                  (!pllSel_q ? mck_pkg::MODE_PLL : mck_pkg::MODE_MAIN);

  // Status flags follow the active mode only
  assign pllRunFlag = (mode_q != mck_pkg::MODE_PLL);
  assign subRunFlag = (mode_q != mck_pkg::MODE_SUB);
  assign regView = {subRunFlag, pllRunFlag, wsSel_q, subSel_q, pllSel_q, multSel_q, 8'h00};

  assign wsLenSel   = wsLen(wsSel_q);
  assign stRun      = (state_q == mck_pkg::ST_RUN);
  assign tDone      = wif.done;
  assign wif.start  = tStart;
  assign wif.len    = tLen;
  assign clkSrc     = mode_q;
  assign clkHold    = (state_q == mck_pkg::ST_STOP);
  assign pllMult    = pllMult_q;
  assign tbtClear   = tStart;
  assign switchBusy = !stRun;

  mck_wait_timer u_timer (
    .clk (clk),
    .rst (rst),
    .w   (wif.tmr)
  );

  // Register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wsSel_q   <= mck_pkg::WS_RESET;
      multSel_q <= mck_pkg::MULT_RESET;
      pllSel_q  <= mck_pkg::PLL_SEL_RESET;
      subSel_q  <= mck_pkg::SUB_SEL_RESET;
    end else if (wrEn) begin
      wsSel_q  <= pwdata[mck_pkg::WS_LO +: 2];
      pllSel_q <= pwdata[mck_pkg::PLL_SEL_BIT];
      subSel_q <= pwdata[mck_pkg::SUB_SEL_BIT];
      if (pllSel_q) begin
        multSel_q <= pwdata[mck_pkg::MULT_LO +: 2];
      end
    end
  end

  // Read data and multiplier factor
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q  <= 32'h0000_0000;
      pllMult_q <= 3'h1;
    end else begin
      pllMult_q <= {1'b0, multSel_q} + 3'h1;
      if (setup) begin
        prdata_q <= mapped ? {16'h0000, regView} : 32'h0000_0000;
      end
    end
  end

  // Mode sequencer
  always_comb begin
    stateD = state_q;
    modeD  = mode_q;
    pendD  = pend_q;
    tStart = 1'b0;
    tLen   = wsLenSel;
    case (state_q)
      mck_pkg::ST_RUN: begin
        if (stopWake) begin
          tStart = 1'b1;
          stateD = mck_pkg::ST_STOP;
        end else if (target != mode_q) begin
          tStart = 1'b1;
          pendD  = target;
          stateD = mck_pkg::ST_SWITCH;
          if (target == mck_pkg::MODE_SUB) begin
            tLen = mck_pkg::SUB_SYNC_LEN;
          end else if (mode_q == mck_pkg::MODE_MAIN) begin
            tLen = WAIT_PLL_FIXED;
          end else if (mode_q == mck_pkg::MODE_PLL) begin
            tLen   = mck_pkg::ALIGN_LEN;
            stateD = mck_pkg::ST_ALIGN;
          end
        end
      end
      mck_pkg::ST_STOP: begin
        if (tDone) begin
          stateD = mck_pkg::ST_RUN;
        end
      end
      mck_pkg::ST_SWITCH: begin
        if (tDone) begin
          modeD  = pend_q;
          stateD = mck_pkg::ST_RUN;
        end
      end
      mck_pkg::ST_ALIGN: begin
        if (tDone || pllMainAligned) begin
          modeD  = mck_pkg::MODE_MAIN;
          stateD = mck_pkg::ST_RUN;
        end
      end
      default: stateD = mck_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= mck_pkg::ST_RUN;
      mode_q  <= mck_pkg::MODE_MAIN;
      pend_q  <= mck_pkg::MODE_MAIN;
    end else begin
      state_q <= stateD;
      mode_q  <= modeD;
      pend_q  <= pendD;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_main_to_pll;
    stRun && !stopWake && mode_q == mck_pkg::MODE_MAIN && target == mck_pkg::MODE_PLL;
  endsequence

  sequence s_sub_to_pll;
    stRun && !stopWake && mode_q == mck_pkg::MODE_SUB && target == mck_pkg::MODE_PLL;
  endsequence

  sequence s_pll_pending;
    state_q == mck_pkg::ST_SWITCH && pend_q == mck_pkg::MODE_PLL;
  endsequence

  a_fixed_pll_wait: assert property (
    s_main_to_pll |-> tStart && tLen == WAIT_PLL_FIXED ##1 s_pll_pending
  ) else $error("main to PLL wait is not the fixed length");

  a_sub_pll_wait: assert property (
    s_sub_to_pll |-> tStart && tLen == wsLen(wsSel_q)
  ) else $error("sub to PLL wait ignores wait select");

  a_stop_exit_wait: assert property (
    stRun && stopWake |-> tStart && tLen == wsLen(wsSel_q) ##1 clkHold && clkSrc == $past(mode_q)
  ) else $error("stop exit wait not started with selected length");

  a_pll_flag_wait: assert property (
    s_pll_pending and !pllSel_q |-> regView[mck_pkg::PLL_FLAG_BIT]
  ) else $error("PLL flag not 1 during PLL wait");

  a_sub_leave_flag: assert property (
    state_q == mck_pkg::ST_SWITCH && pend_q == mck_pkg::MODE_MAIN && mode_q == mck_pkg::MODE_SUB
      |-> !regView[mck_pkg::SUB_FLAG_BIT]
  ) else $error("sub flag not 0 while leaving subclock");

  a_sub_enter_flag: assert property (
    state_q == mck_pkg::ST_SWITCH && pend_q == mck_pkg::MODE_SUB && mode_q != mck_pkg::MODE_SUB
      |-> regView[mck_pkg::SUB_FLAG_BIT]
  ) else $error("sub flag not 1 while entering subclock");

  a_sub_priority: assert property (
    stRun && !stopWake && !subSel_q && !pllSel_q && mode_q != mck_pkg::MODE_SUB
      |=> pend_q == mck_pkg::MODE_SUB
  ) else $error("subclock did not take precedence");

  a_align_bound: assert property (
    $rose(state_q == mck_pkg::ST_ALIGN) |-> ##[1:8] mode_q == mck_pkg::MODE_MAIN
  ) else $error("PLL to main took more than eight cycles");

  a_pll_after_wait: assert property (
    s_pll_pending and tDone |=> mode_q == mck_pkg::MODE_PLL && clkSrc == mck_pkg::MODE_PLL
  ) else $error("PLL not taken at end of wait");

  a_flags_readonly: assert property (
    wrEn && !tDone && !(state_q == mck_pkg::ST_ALIGN) |=> $stable(mode_q)
  ) else $error("register write changed the active mode");

  a_mult_factor: assert property (
    wrEn && pllSel_q |=> ##1 pllMult == {1'b0, $past(pwdata[mck_pkg::MULT_LO +: 2], 2)} + 3'h1
  ) else $error("multiplier factor does not follow field");

  a_ws_reset: assert property (
    disable iff (1'b0) rst |=> wsSel_q == mck_pkg::WS_RESET
  ) else $error("wait select not at reset value");

  a_ws_tap_select: assert property (
    wsLenSel == (wsSel_q[1] ? (wsSel_q[0] ? WAIT_TAP3 : WAIT_TAP2)
                            : (wsSel_q[0] ? WAIT_TAP1 : WAIT_TAP0))
  ) else $error("wait length does not follow wait select");

  a_pll_flag_mode: assert property (
    regView[mck_pkg::PLL_FLAG_BIT] == (clkSrc != mck_pkg::MODE_PLL)
  ) else $error("PLL flag does not match active mode");

  a_sub_flag_mode: assert property (
    regView[mck_pkg::SUB_FLAG_BIT] == (clkSrc != mck_pkg::MODE_SUB)
  ) else $error("sub flag does not match active mode");

  a_mode_legal: assert property (
    clkSrc inside {mck_pkg::MODE_MAIN, mck_pkg::MODE_PLL, mck_pkg::MODE_SUB}
  ) else $error("machine clock mode outside the three modes");

  a_sub_main_wait: assert property (
    stRun && !stopWake && mode_q == mck_pkg::MODE_SUB && target == mck_pkg::MODE_MAIN
      |-> tStart && tLen == wsLen(wsSel_q)
  ) else $error("sub to main wait ignores wait select");

  a_sub_sync_wait: assert property (
    stRun && !stopWake && target == mck_pkg::MODE_SUB && mode_q != mck_pkg::MODE_SUB
      |-> tStart && tLen == mck_pkg::SUB_SYNC_LEN
  ) else $error("subclock entry wait has wrong length");

  a_main_kept_wait: assert property (
    state_q == mck_pkg::ST_SWITCH && !tDone |=> $stable(mode_q)
  ) else $error("clock switched before wait ended");

  a_flags_write_run: assert property (
    wrEn && stRun |=> $stable({regView[mck_pkg::SUB_FLAG_BIT], regView[mck_pkg::PLL_FLAG_BIT]})
  ) else $error("register write changed a status flag");

  a_busy_after_start: assert property (
    tStart |=> switchBusy && tbtClear == 1'b0
  ) else $error("wait start did not raise busy");
endmodule

/* mck_pkg.sv */
// Constants, field layout and types of the machine clock mode block
package mck_pkg;
  localparam int          CLK_HZ        = 20_000_000;
  localparam logic [11:0] CKSEL_OFF     = 12'h000;
  localparam int          WAIT_W        = 18;
  localparam int          MULT_LO       = 8;
  localparam int          PLL_SEL_BIT   = 10;
  localparam int          SUB_SEL_BIT   = 11;
  localparam int          WS_LO         = 12;
  localparam int          PLL_FLAG_BIT  = 14;
  localparam int          SUB_FLAG_BIT  = 15;
  localparam logic [1:0]  WS_RESET      = 2'h3;
  localparam logic [1:0]  MULT_RESET    = 2'h0;
  localparam logic        PLL_SEL_RESET = 1'b1;
  localparam logic        SUB_SEL_RESET = 1'b1;
  localparam int          SUB_SYNC_NS   = 130_000;
  localparam logic [WAIT_W-1:0] SUB_SYNC_LEN =
    WAIT_W'(SUB_SYNC_NS * (CLK_HZ / 1_000_000) / 1000);
  localparam int          PLL_ALIGN_MAX = 8;
  localparam logic [WAIT_W-1:0] ALIGN_LEN = WAIT_W'(PLL_ALIGN_MAX - 1);

  typedef enum logic [1:0] {MODE_MAIN, MODE_PLL, MODE_SUB} mck_mode_t;
  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_SWITCH, ST_ALIGN} mck_state_t;
endpackage

/* mck_wait_if.sv */
// Request and completion signals of the stabilization wait timer
`timescale 1ns/1ps
interface mck_wait_if;
  logic                      start;
  logic [mck_pkg::WAIT_W-1:0] len;
  logic                      busy;
  logic                      done;
  modport ctl (output start, output len, input busy, input done);
  modport tmr (input start, input len, output busy, output done);
endinterface

/* mck_wait_timer.sv */
// Timebase wait counter, cleared and reloaded on every start
`timescale 1ns/1ps
module mck_wait_timer (
  input  logic  clk,
  input  logic  rst,
  mck_wait_if.tmr w
);
  logic [mck_pkg::WAIT_W-1:0] cnt_q;
  logic                       busy_q;
  logic                       done_q;

  assign w.busy = busy_q;
  assign w.done = done_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (w.start) begin
      cnt_q  <= w.len - 1'b1;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - 1'b1;
      busy_q <= (cnt_q != '0);
      done_q <= (cnt_q == '0);
    end else begin
      done_q <= 1'b0;
    end
  end
endmodule
